// ---- core/flash_seq_pkg.sv ----
// Contract
// R1: Host checks lock clear, suspend-ready before suspend
// R2: Suspend handling error sets command lock
// R3: Operation done before suspend: no error, no suspension
// R4: Accepted suspend shows ready plus one suspended flag
// R5: Resume when not suspended: illegal error, lock
// R6: Erase suspended: program other blocks allowed
// R7: Clearing mode entry leaves suspension for read
// R8: Host restores mode entry before resume
// R9: Start clears ready; later raise suspend-ready (not raised for a program started during erase suspension)
// R10: Accepted suspend clears suspend-ready
// R11: Program suspend finishes pulse, then flags, ready
// R12: Program resume clears ready, program-suspended; restarts
// R13: Policy bit: 0 suspension-priority, 1 erasure-priority
// R14: Suspension-priority cuts erase pulse at once
// R15: Each erase pulse cut only once
// R16: Erasure-priority always completes erase pulse
// R17: Erase resume clears ready, erase-suspended; restarts
// R18: Status clear wipes lock and correction flags
// R19: Forced stop resets unit; interrupted op counted
// R20: Blank check direction must match address order
// R21: Blank range in words, 4 bytes to 64K
// R22: Codes 71 then D0 start blank check
// R23: Non-blank data address captured in register
// R24: Command lock refuses all but clear, stop
package flash_seq_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_MODE = 8'h08;
  localparam logic [7:0] OFF_POLICY = 8'h0C;
  localparam logic [7:0] OFF_BLANK_CTRL = 8'h10;
  localparam logic [7:0] OFF_START = 8'h14;
  localparam logic [7:0] OFF_END = 8'h18;
  localparam logic [7:0] OFF_BLANK_RES = 8'h1C;
  localparam logic [7:0] OFF_NONBLANK = 8'h20;
  localparam logic [7:0] OFF_PCOUNT = 8'h24;
  // Status bit positions
  localparam int ST_READY = 0;
  localparam int ST_SUSPEND_READY_FLAG = 1;
  localparam int ST_ESUSP = 2;
  localparam int ST_PSUSP = 3;
  localparam int ST_LOCK = 4;
  localparam int ST_ERR_LSB = 5;
  localparam int ST_CORR_LSB = 11;
  // Lock error vector index: 0 illegal, 1 erase, 2 program, 3 otp, 4 config, 5 table
  localparam int NUM_ERR = 6;
  localparam int NUM_CORR = 3;
  // Command codes
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_PROGRAM = 8'hE8;
  localparam logic [7:0] CMD_BLANK = 8'h71;
  localparam logic [7:0] CMD_GO = 8'hD0;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_CLEAR = 8'h50;
  localparam logic [7:0] CMD_FSTOP = 8'hB3;
  // Timing
  localparam int CLK_NS = 10;
  localparam int PROG_PULSE_NS = 200;
  localparam int ERASE_PULSE_NS = 800;
  localparam logic [15:0] PROG_PULSE_CYC = 16'(PROG_PULSE_NS / CLK_NS);
  localparam logic [15:0] ERASE_PULSE_CYC = 16'(ERASE_PULSE_NS / CLK_NS);
  localparam logic [7:0] PROG_PULSES = 8'h04;
  localparam logic [7:0] ERASE_PULSES = 8'h04;
  // Blank check limits and block size
  localparam logic [31:0] BLANK_MAX_SPAN = 32'h0001_0000;
  localparam logic [31:0] BLANK_DATA = 32'hFFFF_FFFF;
  localparam int BLOCK_SHIFT = 13;
  localparam logic [15:0] MODE_RESET = 16'h0000;
endpackage : flash_seq_pkg

// ---- core/flash_suspend_resume_blank_check.sv ----
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module flash_suspend_resume_blank_check
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [flash_seq_pkg::NUM_ERR-2:0] err_set_i,
  input wire logic [flash_seq_pkg::NUM_CORR-1:0] corr_set_i,
  input wire logic array_rvalid_i,
  input wire logic [31:0] array_rdata_i,
  output logic array_rd_o,
  output logic [31:0] array_addr_o,
  output logic pulse_prog_o,
  output logic pulse_erase_o
);
  import flash_seq_pkg::*;

  typedef enum logic [2:0] {IDLE, PROG, ERASE, BLANK, PSUSP, ESUSP} seq_state_e;

  seq_state_e state;
  logic [15:0] mode_entry_reg;
  logic erase_suspend_policy_bit;
  logic scan_direction_bit;
  logic [31:0] start_address_reg;
  logic [31:0] end_address_reg;
  logic blank_result_flag;
  logic [31:0] nonblank_address_reg;
  logic [31:0] prog_count;
  logic [NUM_ERR-1:0] lock_err;
  logic [NUM_CORR-1:0] corr_flags;
  logic suspend_ready_flag;
  logic susp_pending;
  logic esusp_hold;
  logic erase_cut;
  logic [15:0] pulse_cnt;
  logic [7:0] prog_left;
  logic [7:0] erase_left;
  logic [31:0] erase_block;
  logic [31:0] scan_addr;
  logic [7:0] pend;
  logic command_lock_flag;
  logic sequencer_ready_flag;
  logic erase_suspended_flag;
  logic program_suspended_flag;
  logic bus_write;
  logic cmd_wr;
  logic [7:0] cmd_byte;
  logic mapped;
  logic [31:0] rd_data;
  logic do_fstop;
  logic do_sclr;
  logic do_suspend;
  logic do_resume;
  logic start_prog;
  logic start_erase;
  logic start_blank;
  logic set_illegal;
  logic set_pending;
  logic clear_pending;
  logic range_bad;
  logic [31:0] span;
  logic mode_clear;
  logic cut_now;
  logic pulse_end;
  logic op_done;
  logic busy;

  // Derived status flags
  assign command_lock_flag = |lock_err;
  assign sequencer_ready_flag = (state == IDLE) || (state == PSUSP) || (state == ESUSP);
  assign erase_suspended_flag = (state == ESUSP) || esusp_hold;
  assign program_suspended_flag = (state == PSUSP);
  assign busy = (state == PROG) || (state == ERASE);

  // Bus strobes
  assign bus_write = psel_i && penable_i && pready_o && pwrite_i;
  assign cmd_wr = bus_write && (paddr_i == OFF_CMD);
  assign cmd_byte = pwdata_i[7:0];
  assign mode_clear = bus_write && (paddr_i == OFF_MODE) && (pwdata_i[15:0] == 16'h0000)
                      && ((state == PSUSP) || (state == ESUSP)); // see R7

  // Blank range check, word units
  always_comb
  begin
    span = scan_direction_bit ? (start_address_reg - end_address_reg)
                              : (end_address_reg - start_address_reg);
    range_bad = (scan_direction_bit ? (start_address_reg < end_address_reg)
                                    : (start_address_reg > end_address_reg)) // see R20
                || (span >= BLANK_MAX_SPAN); // see R21
  end

  // Erase pulse cut and pulse completion
  assign cut_now = do_suspend && (state == ERASE) && !erase_suspend_policy_bit
                   && !erase_cut; // see R14, R15, R16
  assign pulse_end = busy && (pulse_cnt == 16'h0001) && !cut_now;
  assign op_done = pulse_end && ((state == PROG) ? (prog_left == 8'h01)
                                                 : (erase_left == 8'h01));

  // Command decode
  always_comb
  begin
    do_fstop = 1'b0;
    do_sclr = 1'b0;
    do_suspend = 1'b0;
    do_resume = 1'b0;
    start_prog = 1'b0;
    start_erase = 1'b0;
    start_blank = 1'b0;
    set_illegal = 1'b0;
    set_pending = 1'b0;
    clear_pending = 1'b0;
    if (cmd_wr)
    begin
      if (cmd_byte == CMD_FSTOP)
        do_fstop = 1'b1; // see R19
      else if (cmd_byte == CMD_CLEAR)
        do_sclr = 1'b1; // see R18
      else if (!command_lock_flag) // see R24
      begin
        if (pend != 8'h00)
        begin
          clear_pending = 1'b1;
          if ((cmd_byte != CMD_GO) || (mode_entry_reg == 16'h0000))
            set_illegal = 1'b1;
          else if (pend == CMD_ERASE)
          begin
            if (state == IDLE)
              start_erase = 1'b1;
            else
              set_illegal = 1'b1;
          end
          else if (pend == CMD_PROGRAM)
          begin
            if ((state == IDLE) || ((state == ESUSP)
                && ((start_address_reg >> BLOCK_SHIFT) != erase_block))) // see R6
              start_prog = 1'b1;
            else
              set_illegal = 1'b1;
          end
          else if ((state == IDLE) && !range_bad)
            start_blank = 1'b1; // see R22
          else
            set_illegal = 1'b1; // see R20
        end
        else if ((cmd_byte == CMD_ERASE) || (cmd_byte == CMD_PROGRAM)
                 || (cmd_byte == CMD_BLANK))
          set_pending = 1'b1;
        else if (cmd_byte == CMD_SUSPEND)
        begin
          if (suspend_ready_flag)
            do_suspend = 1'b1;
          else if (state != IDLE)
            set_illegal = 1'b1; // see R2
          // Operation already finished: ignored quietly, see R3
        end
        else if (cmd_byte == CMD_GO)
        begin
          if ((state == PSUSP) || (state == ESUSP))
            do_resume = 1'b1;
          else
            set_illegal = 1'b1; // see R5
        end
        else
          set_illegal = 1'b1;
      end
    end
  end

  // Pending first byte of two-byte commands
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      pend <= 8'h00;
    else if (do_fstop || clear_pending)
      pend <= 8'h00;
    else if (set_pending)
      pend <= cmd_byte;
  end

  // Operation sequencer and pulse timing
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state <= IDLE;
      susp_pending <= 1'b0;
      esusp_hold <= 1'b0;
      erase_cut <= 1'b0;
      pulse_cnt <= 16'h0000;
      prog_left <= 8'h00;
      erase_left <= 8'h00;
      erase_block <= 32'h0000_0000;
    end
    else if (do_fstop || mode_clear)
    begin
      state <= IDLE; // see R19, R7
      susp_pending <= 1'b0;
      esusp_hold <= 1'b0;
      erase_cut <= 1'b0;
    end
    else
    begin
      unique case (state)
        IDLE:
        begin
          if (start_prog)
          begin
            state <= PROG; // see R9
            prog_left <= PROG_PULSES;
            pulse_cnt <= PROG_PULSE_CYC;
            esusp_hold <= 1'b0;
          end
          else if (start_erase)
          begin
            state <= ERASE; // see R9
            erase_left <= ERASE_PULSES;
            pulse_cnt <= ERASE_PULSE_CYC;
            erase_cut <= 1'b0;
            erase_block <= start_address_reg >> BLOCK_SHIFT;
          end
          else if (start_blank)
            state <= BLANK;
        end
        ESUSP:
        begin
          if (start_prog)
          begin
            state <= PROG;
            prog_left <= PROG_PULSES;
            pulse_cnt <= PROG_PULSE_CYC;
            esusp_hold <= 1'b1; // see R6
          end
          else if (do_resume)
          begin
            state <= ERASE; // see R17
            pulse_cnt <= ERASE_PULSE_CYC;
          end
        end
        PSUSP:
        begin
          if (do_resume)
          begin
            state <= PROG; // see R12
            pulse_cnt <= PROG_PULSE_CYC;
          end
        end
        PROG, ERASE:
        begin
          if (cut_now)
          begin
            state <= ESUSP; // see R14
            erase_cut <= 1'b1; // see R15
            susp_pending <= 1'b0;
          end
          else if (pulse_end)
          begin
            susp_pending <= 1'b0;
            if (state == PROG)
              prog_left <= prog_left - 8'h01;
            else
            begin
              erase_left <= erase_left - 8'h01;
              erase_cut <= 1'b0; // see R15
            end
            if (op_done)
            begin
              state <= esusp_hold ? ESUSP : IDLE; // see R3
              esusp_hold <= 1'b0;
            end
            else if (susp_pending || do_suspend)
              state <= (state == PROG) ? PSUSP : ESUSP; // see R11, R16, R4
            else
              pulse_cnt <= (state == PROG) ? PROG_PULSE_CYC : ERASE_PULSE_CYC;
          end
          else
          begin
            pulse_cnt <= pulse_cnt - 16'h0001;
            if (do_suspend)
              susp_pending <= 1'b1;
          end
        end
        BLANK:
        begin
          if (array_rvalid_i && ((array_rdata_i != BLANK_DATA)
              || (scan_addr[31:2] == end_address_reg[31:2])))
            state <= IDLE;
        end
      endcase
    end
  end

  // Suspend-ready once running and no suspend taken
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      suspend_ready_flag <= 1'b0;
    else
      suspend_ready_flag <= busy && !esusp_hold && !susp_pending && !do_suspend
                            && !do_fstop && !op_done; // see R9, R10
  end

  // Pulse drive towards the array, low one cycle between pulses
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pulse_prog_o <= 1'b0;
      pulse_erase_o <= 1'b0;
    end
    else
    begin
      pulse_prog_o <= (state == PROG) && !do_fstop && !pulse_end; // see R11
      pulse_erase_o <= (state == ERASE) && !do_fstop && !cut_now && !pulse_end; // see R16
    end
  end

  // Blank check scan and result capture
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      scan_addr <= 32'h0000_0000;
      array_rd_o <= 1'b0;
      array_addr_o <= 32'h0000_0000;
      blank_result_flag <= 1'b0;
      nonblank_address_reg <= 32'h0000_0000;
    end
    else if (do_fstop)
      array_rd_o <= 1'b0;
    else if (start_blank)
    begin
      scan_addr <= {start_address_reg[31:2], 2'b00};
      array_addr_o <= {start_address_reg[31:2], 2'b00};
      array_rd_o <= 1'b1;
      blank_result_flag <= 1'b0;
    end
    else if ((state == BLANK) && array_rvalid_i)
    begin
      if (array_rdata_i != BLANK_DATA)
      begin
        blank_result_flag <= 1'b1; // see R22
        nonblank_address_reg <= scan_addr; // see R23
      end
      else if (scan_addr[31:2] != end_address_reg[31:2])
      begin
        scan_addr <= scan_direction_bit ? scan_addr - 32'h4 : scan_addr + 32'h4; // see R21
        array_addr_o <= scan_direction_bit ? scan_addr - 32'h4 : scan_addr + 32'h4;
        array_rd_o <= 1'b1;
      end
    end
    else
      array_rd_o <= 1'b0;
  end

  // Program/erase cycle count, force-stopped ops included
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      prog_count <= 32'h0000_0000;
    else if ((do_fstop && (busy || (state == PSUSP) || (state == ESUSP))) || op_done)
      prog_count <= prog_count + 32'h1; // see R19
  end

  // Lock errors and correction flags, set wins over clear
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      lock_err <= '0;
      corr_flags <= '0;
    end
    else
    begin
      lock_err <= (lock_err & {NUM_ERR{!(do_sclr || do_fstop)}})
                  | {err_set_i, set_illegal}; // see R2, R5, R18, R24
      corr_flags <= (corr_flags & {NUM_CORR{!do_sclr}}) | corr_set_i; // see R18
    end
  end

  // Software registers
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mode_entry_reg <= MODE_RESET;
      erase_suspend_policy_bit <= 1'b0;
      scan_direction_bit <= 1'b0;
      start_address_reg <= 32'h0000_0000;
      end_address_reg <= 32'h0000_0000;
    end
    else if (bus_write)
    begin
      unique case (paddr_i)
        OFF_MODE: mode_entry_reg <= pwdata_i[15:0];
        OFF_POLICY: erase_suspend_policy_bit <= pwdata_i[0]; // see R13
        OFF_BLANK_CTRL: scan_direction_bit <= pwdata_i[0];
        OFF_START: start_address_reg <= pwdata_i;
        OFF_END: end_address_reg <= pwdata_i;
        default: ;
      endcase
    end
  end

  // Read data mux
  always_comb
  begin
    mapped = 1'b1;
    rd_data = 32'h0000_0000;
    unique case (paddr_i)
      OFF_CMD: rd_data = 32'h0000_0000;
      OFF_STATUS:
      begin
        rd_data[ST_READY] = sequencer_ready_flag;
        rd_data[ST_SUSPEND_READY_FLAG] = suspend_ready_flag;
        rd_data[ST_ESUSP] = erase_suspended_flag;
        rd_data[ST_PSUSP] = program_suspended_flag;
        rd_data[ST_LOCK] = command_lock_flag;
        rd_data[ST_ERR_LSB +: NUM_ERR] = lock_err;
        rd_data[ST_CORR_LSB +: NUM_CORR] = corr_flags;
      end
      OFF_MODE: rd_data[15:0] = mode_entry_reg;
      OFF_POLICY: rd_data[0] = erase_suspend_policy_bit;
      OFF_BLANK_CTRL: rd_data[0] = scan_direction_bit;
      OFF_START: rd_data = start_address_reg;
      OFF_END: rd_data = end_address_reg;
      OFF_BLANK_RES: rd_data[0] = blank_result_flag;
      OFF_NONBLANK: rd_data = nonblank_address_reg;
      OFF_PCOUNT: rd_data = prog_count;
      default: mapped = 1'b0;
    endcase
  end

  // APB answer, one wait-free access phase
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end
    else
    begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i && !mapped;
      if (psel_i && !penable_i && !pwrite_i)
        prdata_o <= rd_data;
    end
  end
endmodule : flash_suspend_resume_blank_check
`default_nettype wire

// ---- dv/flash_seq_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module flash_seq_monitor
  import flash_seq_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [flash_seq_pkg::NUM_ERR-2:0] err_set_i,
  input wire logic [flash_seq_pkg::NUM_CORR-1:0] corr_set_i,
  input wire logic array_rvalid_i,
  input wire logic [31:0] array_rdata_i,
  input wire logic array_rd_o,
  input wire logic [31:0] array_addr_o,
  input wire logic pulse_prog_o,
  input wire logic pulse_erase_o
);
  logic [15:0] prog_run;
  logic [15:0] erase_run;
  // Length of the pulse now applied
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      prog_run <= 16'h0000;
      erase_run <= 16'h0000;
    end
    else
    begin
      prog_run <= pulse_prog_o ? prog_run + 16'h0001 : 16'h0000;
      erase_run <= pulse_erase_o ? erase_run + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Bus answer, array read and pulse checks
  property p_ready_after_setup; psel_i && !penable_i |=> pready_o; endproperty
  a_ready_after_setup: assert property (p_ready_after_setup)
    else $error("no ready after setup");
  property p_ready_cause; pready_o |-> $past(psel_i && !penable_i); endproperty
  a_ready_cause: assert property (p_ready_cause)
    else $error("ready without setup");
  property p_ready_single; pready_o |=> !pready_o; endproperty
  a_ready_single: assert property (p_ready_single)
    else $error("ready longer than one cycle");
  property p_err_with_ready; pslverr_o |-> pready_o; endproperty
  a_err_with_ready: assert property (p_err_with_ready)
    else $error("slave error without ready");
  property p_rd_single; array_rd_o |=> !array_rd_o; endproperty
  a_rd_single: assert property (p_rd_single)
    else $error("array read longer than one cycle");
  property p_addr_hold; array_rd_o ##1 !array_rvalid_i |-> $stable(array_addr_o); endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("array address moved while waiting");
  property p_pulses_apart; !(pulse_prog_o && pulse_erase_o); endproperty
  a_pulses_apart: assert property (p_pulses_apart)
    else $error("program and erase pulse together");
  property p_prog_len; prog_run <= PROG_PULSE_CYC; endproperty
  a_prog_len: assert property (p_prog_len)
    else $error("program pulse too long");
  property p_erase_len; erase_run <= ERASE_PULSE_CYC; endproperty
  a_erase_len: assert property (p_erase_len)
    else $error("erase pulse too long");
endmodule : flash_seq_monitor
bind flash_suspend_resume_blank_check flash_seq_monitor flash_seq_monitor_inst (.clk_i, .rst_i,
  .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
  .err_set_i, .corr_set_i, .array_rvalid_i, .array_rdata_i, .array_rd_o, .array_addr_o,
  .pulse_prog_o, .pulse_erase_o);
`default_nettype wire

// ---- dv/flash_array_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module flash_array_model
  import flash_seq_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rd_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] bad_addr_i,
  input wire logic [3:0] lat_i,
  output logic rvalid_o,
  output logic [31:0] rdata_o
);
  logic busy;
  logic [3:0] cnt;
  logic [31:0] addr;
  // One read at a time, answered after lat_i cycles; data churns otherwise
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      busy <= 1'b0;
      cnt <= 4'h0;
      addr <= 32'h0000_0000;
      rvalid_o <= 1'b0;
      rdata_o <= 32'h0000_0000;
    end
    else
    begin
      rvalid_o <= 1'b0;
      rdata_o <= ~rdata_o;
      if (rd_i)
      begin
        busy <= 1'b1;
        cnt <= lat_i;
        addr <= addr_i;
      end
      else if (busy && cnt <= 4'h1)
      begin
        busy <= 1'b0;
        rvalid_o <= 1'b1;
        rdata_o <= (addr == bad_addr_i) ? 32'h0000_5A5A : BLANK_DATA;
      end
      else if (busy)
      begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule : flash_array_model
`default_nettype wire

// ---- dv/flash_suspend_resume_blank_check_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module flash_suspend_resume_blank_check_tb;
  import flash_seq_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [NUM_ERR-2:0] err_set_i = '0;
  logic [NUM_CORR-1:0] corr_set_i = '0;
  logic [31:0] bad_addr = 32'h0000_0000;
  logic [3:0] lat = 4'h1;
  logic [31:0] prdata_o, array_addr_o, array_rdata_i, rd;
  logic pready_o, pslverr_o, array_rd_o, array_rvalid_i, pulse_prog_o, pulse_erase_o, last_err;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int test_no = 0;
  int t0;
  // Blank check cases: direction, start, end, bad word, result
  logic [31:0] bc_dir [4] = '{32'h0, 32'h1, 32'h0, 32'h1};
  logic [31:0] bc_s [4] = '{32'h100, 32'h11C, 32'h200, 32'h100};
  logic [31:0] bc_e [4] = '{32'h11C, 32'h100, 32'h200, 32'h11C};
  logic [31:0] bc_bad [4] = '{32'h110, 32'h10C, 32'h0, 32'h0};
  logic [31:0] bc_res [4] = '{32'h1, 32'h1, 32'h0, 32'h0};
  flash_suspend_resume_blank_check flash_suspend_resume_blank_check_inst (.clk_i, .rst_i,
    .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
    .err_set_i, .corr_set_i, .array_rvalid_i, .array_rdata_i, .array_rd_o, .array_addr_o,
    .pulse_prog_o, .pulse_erase_o);
  flash_array_model flash_array_model_inst (.clk_i, .rst_i, .rd_i(array_rd_o),
    .addr_i(array_addr_o), .bad_addr_i(bad_addr), .lat_i(lat), .rvalid_o(array_rvalid_i),
    .rdata_o(array_rdata_i));
  // Clock
  initial
  begin
    forever #5 clk_i = ~clk_i;
  end
  // Hang guard
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      final_report();
    end
  end
  task final_report();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report
  task chk(input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : chk
  // One APB transfer, held until pready is sampled
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1 && n < 20)
    begin
      @(posedge clk_i);
      n++;
    end
    chk(32'h0, 32'(n == 20));
    rd = prdata_o;
    last_err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task cmd(input logic [7:0] c);
    apb(1'b1, OFF_CMD, {24'h0, c});
  endtask : cmd
  task st(input logic [31:0] exp);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(exp, rd);
  endtask : st
  // Poll a status bit with a bound
  task wait_bit(input int b, input logic v);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, OFF_STATUS, 32'h0);
      n++;
    end
    while (rd[b] !== v && n < 200);
    chk(32'h0, 32'(n == 200));
  endtask : wait_bit
  task done_test();
    test_no++;
    $display("test %0d finished", test_no);
  endtask : done_test
  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    st(32'h1);
    apb(1'b1, OFF_MODE, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, OFF_BLANK_CTRL, bc_dir[i]);
      apb(1'b1, OFF_START, bc_s[i]);
      apb(1'b1, OFF_END, bc_e[i]);
      bad_addr <= bc_bad[i];
      lat <= 4'(i + 1);
      cmd(CMD_BLANK);
      cmd(CMD_GO);
      wait_bit(ST_READY, 1'b1);
      if (i == 3)
      begin
        chk(32'h31, rd);
        cmd(CMD_ERASE);
        cmd(CMD_GO);
        st(32'h31);
        cmd(CMD_CLEAR);
        st(32'h1);
      end
      else
      begin
        apb(1'b0, OFF_BLANK_RES, 32'h0);
        chk(bc_res[i], rd);
        apb(1'b0, OFF_NONBLANK, 32'h0);
        if (bc_res[i][0])
          chk(bc_bad[i], rd);
      end
    end
    done_test();
    apb(1'b1, OFF_START, 32'h4000);
    cmd(CMD_PROGRAM);
    cmd(CMD_GO);
    wait_bit(ST_SUSPEND_READY_FLAG, 1'b1);
    chk(32'h2, rd & 32'h3);
    cmd(CMD_SUSPEND);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(32'h0, rd & 32'h12);
    wait_bit(ST_READY, 1'b1);
    chk(32'h9, rd);
    cmd(CMD_GO);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(32'h0, rd & 32'h9);
    wait_bit(ST_READY, 1'b1);
    chk(32'h1, rd);
    cmd(CMD_SUSPEND);
    st(32'h1);
    done_test();
    cmd(CMD_GO);
    st(32'h31);
    cmd(CMD_FSTOP);
    st(32'h1);
    done_test();
    for (int p = 0; p < 2; p++)
    begin
      apb(1'b1, OFF_POLICY, 32'(p));
      apb(1'b1, OFF_START, 32'h0);
      cmd(CMD_ERASE);
      cmd(CMD_GO);
      wait_bit(ST_SUSPEND_READY_FLAG, 1'b1);
      cmd(CMD_SUSPEND);
      t0 = cycles;
      wait_bit(ST_READY, 1'b1);
      chk(32'h5, rd);
      if (p == 0)
      begin
        chk(32'h1, 32'((cycles - t0) < 16));
        // Resumed cut pulse must run to its end on a second suspend
        cmd(CMD_GO);
        wait_bit(ST_SUSPEND_READY_FLAG, 1'b1);
        cmd(CMD_SUSPEND);
        t0 = cycles;
        wait_bit(ST_READY, 1'b1);
        chk(32'h5, rd);
        chk(32'h1, 32'((cycles - t0) > 16));
        apb(1'b1, OFF_START, 32'h4000);
        cmd(CMD_PROGRAM);
        cmd(CMD_GO);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(32'h0, rd & 32'h11);
        wait_bit(ST_READY, 1'b1);
        chk(32'h5, rd);
        apb(1'b1, OFF_MODE, 32'h0);
        st(32'h1);
        apb(1'b1, OFF_MODE, 32'h1);
      end
      else
      begin
        cmd(CMD_GO);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(32'h0, rd & 32'h5);
        cmd(CMD_FSTOP);
        st(32'h1);
      end
    end
    done_test();
    @(posedge clk_i);
    err_set_i <= 5'h01;
    corr_set_i <= 3'h1;
    @(posedge clk_i);
    err_set_i <= 5'h00;
    corr_set_i <= 3'h0;
    st(32'h851);
    cmd(CMD_CLEAR);
    st(32'h1);
    apb(1'b0, OFF_PCOUNT, 32'h0);
    chk(32'h3, rd);
    apb(1'b0, 8'h3C, 32'h0);
    chk(32'h1, {31'h0, last_err});
    done_test();
    final_report();
  end
endmodule : flash_suspend_resume_blank_check_tb
`default_nettype wire
